// ### logic/app_config_regs.v
// Purpose: Analog power control and PLL divisor registers of an audio codec
// Assumes: Host port is synchronous to mclk; strobes never overlap
// Notes: Read data appear in the cycle after the read strobe only
`timescale 1ns/1ns
`include "app_config_regs_defs.vh"

module app_config_regs #(
  parameter RAMP_CYCLES = `APP_RAMP_CYCLES
) (
  input wire mclk,
  input wire reset,
  input wire clockEnable,
  input wire [15:0] regAddr,
  input wire [15:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [15:0] regRdData,
  output wire chargePumpPowerOn,
  output wire pllPowerOn,
  output wire coreRegulatorPowerOn,
  output wire oscillatorAmpPowerOn,
  output wire analogGroundBufferOn,
  output reg rampUpStart,
  output reg rampDownStart,
  output wire rampActive,
  output wire adcLeftOnly,
  output wire adcStereo,
  output wire referenceBiasOn,
  output wire headphonePowerOn,
  output wire dacPowerOn,
  output wire caplessHeadphoneOn,
  output wire adcPowerOn,
  output wire lineoutPowerOn,
  output wire [4:0] synthIntegerDiv,
  output wire [10:0] synthFractionDiv,
  output wire internalOscOn,
  output wire inputClockHalve
);

  // ****************************************
  // Storage
  // ****************************************
  reg [11:0] power_reg;
  reg [11:0] power_next;
  reg [4:0] intDiv_reg;
  reg [4:0] intDiv_next;
  reg [10:0] fracDiv_reg;
  reg [10:0] fracDiv_next;
  reg halve_reg;
  reg halve_next;
  reg intOsc_reg;
  reg intOsc_next;
  reg [15:0] rdData_next;
  reg rampUp_next;
  reg rampDown_next;

  // Ramp sequencer
  localparam RAMP_IDLE = 2'b00;
  localparam RAMP_UP = 2'b01;
  localparam RAMP_DOWN = 2'b10;
  localparam [`APP_RAMP_CNT_W-1:0] RAMP_LAST = RAMP_CYCLES[`APP_RAMP_CNT_W-1:0] - 1'b1;

  reg [1:0] rampState_reg;
  reg [1:0] rampState_next;
  reg [`APP_RAMP_CNT_W-1:0] rampCnt_reg;
  reg [`APP_RAMP_CNT_W-1:0] rampCnt_next;

  // ****************************************
  // Address decode
  // ****************************************
  wire hitPower;
  wire hitPll;
  wire hitClkTop;
  wire hitStatus;
  wire wrPower;
  wire wrPll;
  wire wrClkTop;
  wire pllLockout;
  wire agndNew;

  assign hitPower = (regAddr == `APP_OFS_POWER);
  assign hitPll = (regAddr == `APP_OFS_PLL);
  assign hitClkTop = (regAddr == `APP_OFS_CLKTOP);
  assign hitStatus = (regAddr == `APP_OFS_STATUS);
  assign wrPower = regWrite && hitPower;
  assign wrClkTop = regWrite && hitClkTop;

  // RL6 divisor write lockout
  // Divisors are frozen while the PLL runs, so a live PLL never sees a jump
  assign pllLockout = power_reg[`APP_PWR_PLL];
  assign wrPll = regWrite && hitPll && !pllLockout;

  assign agndNew = regWrData[`APP_PWR_AGND];

  // ****************************************
  // Register write logic
  // ****************************************
  always @* begin
    power_next = power_reg;
    intDiv_next = intDiv_reg;
    fracDiv_next = fracDiv_reg;
    halve_next = halve_reg;
    intOsc_next = intOsc_reg;
    // RL19 hold last write
    if (wrPower) begin
      power_next = regWrData[11:0];
    end
    // RL15 integer divisor field
    // RL17 fraction divisor field
    if (wrPll) begin
      intDiv_next = regWrData[`APP_PLL_INT_MSB:`APP_PLL_INT_LSB];
      fracDiv_next = regWrData[`APP_PLL_FRAC_MSB:`APP_PLL_FRAC_LSB];
    end
    // RL18 input halving control
    if (wrClkTop) begin
      halve_next = regWrData[`APP_CLK_HALVE];
      intOsc_next = regWrData[`APP_CLK_INT_OSC];
    end
  end

  // ****************************************
  // Analog-ground ramp sequencer
  // ****************************************
  always @* begin
    rampState_next = rampState_reg;
    rampCnt_next = rampCnt_reg;
    rampUp_next = 1'b0;
    rampDown_next = 1'b0;
    // RL9 ramp start on edge
    if (wrPower && agndNew && !power_reg[`APP_PWR_AGND]) begin
      rampUp_next = 1'b1;
      rampState_next = RAMP_UP;
      rampCnt_next = {`APP_RAMP_CNT_W{1'b0}};
    end else if (wrPower && !agndNew && power_reg[`APP_PWR_AGND]) begin
      rampDown_next = 1'b1;
      rampState_next = RAMP_DOWN;
      rampCnt_next = {`APP_RAMP_CNT_W{1'b0}};
    end else begin
      case (rampState_reg)
        RAMP_IDLE: begin
          rampCnt_next = {`APP_RAMP_CNT_W{1'b0}};
        end
        RAMP_UP, RAMP_DOWN: begin
          // RL10 ramp-up and ramp-down duration
          if (rampCnt_reg == RAMP_LAST) begin
            rampState_next = RAMP_IDLE;
            rampCnt_next = {`APP_RAMP_CNT_W{1'b0}};
          end else begin
            rampCnt_next = rampCnt_reg + {{(`APP_RAMP_CNT_W-1){1'b0}}, 1'b1};
          end
        end
        default: begin
          rampState_next = RAMP_IDLE;
          rampCnt_next = {`APP_RAMP_CNT_W{1'b0}};
        end
      endcase
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always @* begin
    rdData_next = 16'h0000;
    if (regRead) begin
      if (hitPower) begin
        rdData_next = {4'h0, power_reg};
      end else if (hitPll) begin
        rdData_next = {intDiv_reg, fracDiv_reg};
      end else if (hitClkTop) begin
        rdData_next[`APP_CLK_HALVE] = halve_reg;
        rdData_next[`APP_CLK_INT_OSC] = intOsc_reg;
      end else if (hitStatus) begin
        rdData_next[`APP_STS_RAMP_BUSY] = (rampState_reg != RAMP_IDLE);
        rdData_next[`APP_STS_RAMP_DIR] = (rampState_reg == RAMP_DOWN);
        rdData_next[`APP_STS_PLL_LOCKOUT] = pllLockout;
      end else begin
        rdData_next = 16'h0000;
      end
    end
  end

  // ****************************************
  // State registers
  // ****************************************
  always @(posedge mclk) begin
    if (reset) begin
      // RL12 reference bias on
      power_reg <= `APP_PWR_RESET;
      intDiv_reg <= `APP_PLL_INT_RESET;
      fracDiv_reg <= `APP_PLL_FRAC_RESET;
      halve_reg <= 1'b0;
      intOsc_reg <= 1'b0;
      rampState_reg <= RAMP_IDLE;
      rampCnt_reg <= {`APP_RAMP_CNT_W{1'b0}};
      rampUpStart <= 1'b0;
      rampDownStart <= 1'b0;
      regRdData <= 16'h0000;
    end else if (clockEnable) begin
      power_reg <= power_next;
      intDiv_reg <= intDiv_next;
      fracDiv_reg <= fracDiv_next;
      halve_reg <= halve_next;
      intOsc_reg <= intOsc_next;
      rampState_reg <= rampState_next;
      rampCnt_reg <= rampCnt_next;
      rampUpStart <= rampUp_next;
      rampDownStart <= rampDown_next;
      regRdData <= rdData_next;
    end
  end

  // ****************************************
  // Power controls to the analog blocks
  // ****************************************
  assign chargePumpPowerOn = power_reg[`APP_PWR_PUMP];
  // RL3 PLL power gate
  assign pllPowerOn = power_reg[`APP_PWR_PLL];
  // RL7 core regulator power
  assign coreRegulatorPowerOn = power_reg[`APP_PWR_CORE_REG];
  // RL8 VCO amplifier power
  assign oscillatorAmpPowerOn = power_reg[`APP_PWR_VCOAMP];
  // RL9 ground buffer enable
  assign analogGroundBufferOn = power_reg[`APP_PWR_AGND];
  assign rampActive = (rampState_reg != RAMP_IDLE);
  // RL11 ADC mono select
  assign adcLeftOnly = power_reg[`APP_PWR_ADC] && !power_reg[`APP_PWR_ADCMONO];
  assign adcStereo = power_reg[`APP_PWR_ADC] && power_reg[`APP_PWR_ADCMONO];
  // RL12 reference bias enable
  assign referenceBiasOn = power_reg[`APP_PWR_REFBIAS];
  // RL13 amplifier and converter power
  assign headphonePowerOn = power_reg[`APP_PWR_HEADPHONE];
  assign dacPowerOn = power_reg[`APP_PWR_DAC];
  assign adcPowerOn = power_reg[`APP_PWR_ADC];
  assign lineoutPowerOn = power_reg[`APP_PWR_LINEOUT];
  // RL14 capless headphone mode
  assign caplessHeadphoneOn = power_reg[`APP_PWR_CAPLESS];

  // ****************************************
  // PLL divisor and clock-top controls
  // ****************************************
  // RL15 integer divisor out
  assign synthIntegerDiv = intDiv_reg;
  // RL17 fraction divisor out
  assign synthFractionDiv = fracDiv_reg;
  // RL18 halve the input clock
  assign inputClockHalve = halve_reg;
  assign internalOscOn = intOsc_reg;

endmodule

// ### logic/app_config_regs_defs.vh
// Purpose: Constants for the analog power and PLL divisor register bank
// Assumes: 16-bit registers on a plain address/strobe port, one clock
// Notes: Offsets are byte addresses of 16-bit registers
//
// Notes on behaviour
// RL1 - Software clears pump bit without 3V supply
// RL2 - Pump needs PLL or internal oscillator clock
// RL3 - PLL runs only while its bit is set
// RL4 - Set PLL bit before PLL-derived clock code
// RL5 - Program divisors before powering the PLL
// RL6 - Divisors writable only before PLL power-up
// RL7 - Bit 9 powers core-supply linear regulator
// RL8 - Bit 8 powers the VCO amplifier
// RL9 - Ground buffer bit starts ramp up/down
// RL10 - Keep outputs powered through 200-400ms ramp-down
// RL11 - ADC mono bit: 0 left only, 1 stereo
// RL12 - Reference bias resets on, may sleep
// RL13 - Bits 4,3,1,0 power HP, DAC, ADC, lineout
// RL14 - Bit 2 enables capless headphone mode
// RL15 - Integer divisor bits 15:11, reset 0xA
// RL16 - PLL target 180.6336 or 196.608 MHz
// RL17 - Fraction divisor bits 10:0, times 2048
// RL18 - Halving control divides PLL input clock
// RL19 - Fields hold and read back last write
`ifndef APP_CONFIG_REGS_DEFS_VH
`define APP_CONFIG_REGS_DEFS_VH

// ****************************************
// Register offsets
// ****************************************
`define APP_OFS_POWER 16'h0030
`define APP_OFS_PLL 16'h0032
`define APP_OFS_CLKTOP 16'h0034
`define APP_OFS_STATUS 16'h003C

// ****************************************
// Power register fields
// ****************************************
`define APP_PWR_LINEOUT 0
`define APP_PWR_ADC 1
`define APP_PWR_CAPLESS 2
`define APP_PWR_DAC 3
`define APP_PWR_HEADPHONE 4
`define APP_PWR_REFBIAS 5
`define APP_PWR_ADCMONO 6
`define APP_PWR_AGND 7
`define APP_PWR_VCOAMP 8
`define APP_PWR_CORE_REG 9
`define APP_PWR_PLL 10
`define APP_PWR_PUMP 11
`define APP_PWR_RESET 12'h060

// ****************************************
// PLL divisor fields
// ****************************************
`define APP_PLL_INT_MSB 15
`define APP_PLL_INT_LSB 11
`define APP_PLL_FRAC_MSB 10
`define APP_PLL_FRAC_LSB 0
`define APP_PLL_INT_RESET 5'h0A
`define APP_PLL_FRAC_RESET 11'h000

// ****************************************
// Clock-top and status fields
// ****************************************
`define APP_CLK_HALVE 3
`define APP_CLK_INT_OSC 11
`define APP_STS_RAMP_BUSY 0
`define APP_STS_RAMP_DIR 1
`define APP_STS_PLL_LOCKOUT 2

// ****************************************
// Timing
// ****************************************
`define APP_CLK_KHZ 50000
`define APP_RAMP_TIME_MS 400
`define APP_RAMP_CYCLES (`APP_RAMP_TIME_MS * `APP_CLK_KHZ)
`define APP_RAMP_CNT_W 25

`endif

// ### verif/app_config_regs_checker.sv
// Purpose: Port-level checks of the power and divisor register bank
// Assumes: Single clock, synchronous active-high reset
// Notes: Attached to the design by bind
`timescale 1ns/1ns
module app_config_regs_checker (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clockEnable,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regRdData,
  input wire logic chargePumpPowerOn,
  input wire logic pllPowerOn,
  input wire logic coreRegulatorPowerOn,
  input wire logic oscillatorAmpPowerOn,
  input wire logic analogGroundBufferOn,
  input wire logic rampUpStart,
  input wire logic rampDownStart,
  input wire logic rampActive,
  input wire logic adcLeftOnly,
  input wire logic adcStereo,
  input wire logic adcPowerOn,
  input wire logic [4:0] synthIntegerDiv,
  input wire logic [10:0] synthFractionDiv
);
  wire logic [4:0] upBits = {chargePumpPowerOn, pllPowerOn, coreRegulatorPowerOn,
    oscillatorAmpPowerOn, analogGroundBufferOn};
  wire logic [15:0] divs = {synthIntegerDiv, synthFractionDiv};
  wire logic wrPwr = clockEnable && regWrite && regAddr == 16'h0030;
  wire logic wrPll = clockEnable && regWrite && regAddr == 16'h0032;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  property p_pwr; wrPwr |=> upBits == $past(regWrData[11:7]); endproperty
  a_pwr: assert property (p_pwr) else $error("power bits differ from write");
  property p_hold; clockEnable && !regWrite |=> $stable(upBits) && $stable(divs); endproperty
  a_hold: assert property (p_hold) else $error("register moved without write");
  property p_div; wrPll && !pllPowerOn |=> divs == $past(regWrData); endproperty
  a_div: assert property (p_div) else $error("divisor write lost");
  property p_lock; wrPll && pllPowerOn |=> $stable(divs); endproperty
  a_lock: assert property (p_lock) else $error("divisor changed while PLL on");
  property p_rdz; clockEnable && !regRead |=> regRdData == 16'h0000; endproperty
  a_rdz: assert property (p_rdz) else $error("read data not cleared");
  property p_rdp; clockEnable && regRead && regAddr == 16'h0030
    |=> regRdData[15:7] == {4'h0, upBits}; endproperty
  a_rdp: assert property (p_rdp) else $error("power read mismatch");
  property p_mono; (adcLeftOnly || adcStereo) == adcPowerOn && !(adcLeftOnly && adcStereo);
  endproperty
  a_mono: assert property (p_mono) else $error("ADC mode outputs wrong");
  property p_up; wrPwr && regWrData[7] && !analogGroundBufferOn
    |=> rampUpStart && rampActive ##1 !rampUpStart; endproperty
  a_up: assert property (p_up) else $error("ramp up not started");
  property p_dn; wrPwr && !regWrData[7] && analogGroundBufferOn
    |=> rampDownStart && rampActive ##1 !rampDownStart; endproperty
  a_dn: assert property (p_dn) else $error("ramp down not started");
  c_up: cover property (wrPwr && regWrData[7] && !analogGroundBufferOn);
  c_lock: cover property (wrPll && pllPowerOn);
  c_rd: cover property (clockEnable && regRead && regAddr == 16'h0030);
endmodule
bind app_config_regs app_config_regs_checker app_config_regs_checker_inst (.mclk, .reset,
  .clockEnable, .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .chargePumpPowerOn,
  .pllPowerOn, .coreRegulatorPowerOn, .oscillatorAmpPowerOn, .analogGroundBufferOn,
  .rampUpStart, .rampDownStart, .rampActive, .adcLeftOnly, .adcStereo, .adcPowerOn,
  .synthIntegerDiv, .synthFractionDiv);

// ### verif/app_host_model.sv
// Purpose: Host side of the register port
// Assumes: Tasks are entered just after a rising edge
// Notes: Data lines are inverted once released
`timescale 1ns/1ns
module app_host_model (
  input wire logic mclk,
  input wire logic [15:0] regRdData,
  output logic [15:0] regAddr = 16'h0000,
  output logic [15:0] regWrData = 16'h0000,
  output logic regWrite = 1'b0,
  output logic regRead = 1'b0
);
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
    regWrData <= ~d;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1;
    d = regRdData;
    @(posedge mclk);
  endtask
endmodule

// ### verif/app_config_regs_tb.sv
// Purpose: Self-checking bench of the power and divisor register bank
// Assumes: Ramp shortened to 8 cycles
// Notes: Bus cycles come from the host model
`timescale 1ns/1ns
module app_config_regs_tb;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic clockEnable = 1'b1;
  logic [15:0] regAddr, regWrData, regRdData, rdv, d;
  logic regWrite, regRead, rampUp, rampDn, rampAct, adcLeft, intOsc, halve;
  wire [11:0] pw;
  logic [4:0] intDiv;
  logic [10:0] fracDiv;
  int miscompares = 0;
  int checks_done = 0;
  app_host_model host (.mclk(mclk), .regRdData(regRdData), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead));
  app_config_regs #(.RAMP_CYCLES(8)) app_config_regs_inst (.mclk(mclk), .reset(reset),
    .clockEnable(clockEnable), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .chargePumpPowerOn(pw[11]), .pllPowerOn(pw[10]), .coreRegulatorPowerOn(pw[9]),
    .oscillatorAmpPowerOn(pw[8]), .analogGroundBufferOn(pw[7]), .rampUpStart(rampUp),
    .rampDownStart(rampDn), .rampActive(rampAct), .adcLeftOnly(adcLeft),
    .adcStereo(pw[6]), .referenceBiasOn(pw[5]), .headphonePowerOn(pw[4]),
    .dacPowerOn(pw[3]), .caplessHeadphoneOn(pw[2]), .adcPowerOn(pw[1]),
    .lineoutPowerOn(pw[0]), .synthIntegerDiv(intDiv), .synthFractionDiv(fracDiv),
    .internalOscOn(intOsc), .inputClockHalve(halve));
  initial begin
    forever #10 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
    host.rd(a, rdv);
    chk("read", exp, rdv);
  endtask
  task automatic ramp_len;
    int n;
    n = 1;
    #1;
    while (rampAct === 1'b1 && n < 50) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("ramp", 16'd8, n[15:0]);
    @(posedge mclk);
  endtask
  task automatic finish_test;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rdchk(16'h0030, 16'h0060);
    rdchk(16'h0032, 16'h5000);
    rdchk(16'h0034, 16'h0000);
    chk("power", 16'h0020, {4'h0, pw});
    for (int i = 0; i < 12; i++) begin
      d = 16'hF002 | (16'h0001 << i);
      host.wr(16'h0030, d);
      chk("power", {4'h0, d[11:0]}, {4'h0, pw});
      chk("left", {15'h0, ~d[6]}, {15'h0, adcLeft});
      rdchk(16'h0030, d & 16'h0FFF);
    end
    host.wr(16'h0030, 16'h0000);
    host.wr(16'h0034, 16'hFFFF);
    rdchk(16'h0034, 16'h0808);
    chk("clktop", 16'h0003, {14'h0, intOsc, halve});
    // 196.608 MHz from halved 24 MHz
    host.wr(16'h0032, 16'h8312);
    chk("divisor", 16'h8312, {intDiv, fracDiv});
    host.wr(16'h0030, 16'h0500);
    host.wr(16'h0032, 16'h1234);
    rdchk(16'h0032, 16'h8312);
    rdchk(16'h003C, 16'h0004);
    host.wr(16'h0040, 16'hFFFF);
    rdchk(16'h0040, 16'h0000);
    clockEnable <= 1'b0;
    host.wr(16'h0030, 16'h0000);
    clockEnable <= 1'b1;
    chk("frozen", 16'h0500, {4'h0, pw});
    host.wr(16'h0030, 16'h0590);
    ramp_len();
    host.wr(16'h0030, 16'h0510);
    ramp_len();
    chk("power", 16'h0510, {4'h0, pw});
    finish_test();
  end
endmodule
